// ### src/agc_pkg.sv
// shared constants, types and register map for the signal chain control
package agc_pkg;

  // register map, byte-wide registers on the serial port
  localparam logic [7:0] REG_GAIN_GR   = 8'h00;
  localparam logic [7:0] REG_GAIN_RED  = 8'h01;
  localparam logic [7:0] REG_GAIN_BLUE = 8'h02;
  localparam logic [7:0] REG_GAIN_GBG  = 8'h03;
  localparam logic [7:0] REG_CLAMP_CFG = 8'h08;
  localparam logic [7:0] REG_GAIN_MODE = 8'h09;
  localparam logic [7:0] REG_COL_DC    = 8'h0A;
  localparam logic [7:0] REG_GLOB_OFS  = 8'h0B;
  localparam logic [7:0] REG_STATUS    = 8'h0C;
  localparam logic [7:0] REG_EXP_A     = 8'h10;
  localparam logic [7:0] REG_EXP_B     = 8'h21;
  localparam logic [1:0] REG_TAB_PAGE  = 2'h1;  // 0x40..0x7f, table

  // serial slave address, value is arbitrary
  localparam logic [6:0] DEV_ADDR = 7'h2A;

  // field positions and reset values
  localparam int unsigned CLAMP_EN_BIT   = 0;
  localparam int unsigned CLAMP_ROWS_LSB = 1;
  localparam logic [7:0]  CLAMP_CFG_RST  = 8'h05;  // on, two rows
  localparam int unsigned WB_MODE_BIT    = 0;
  localparam int unsigned EXP_MODE_LSB   = 1;
  localparam logic [7:0]  GAIN_MODE_RST  = 8'h00;
  localparam logic [5:0]  CODE_RST       = 6'h00;
  localparam logic [5:0]  COL_DC_RST     = 6'h00;
  localparam int unsigned SIGN_BIT       = 5;

  // clamp sequencing
  localparam logic [2:0] CLAMP_SKIP_ROWS = 3'h3;
  localparam int unsigned COL_ENTRIES    = 64;

  // gain code limits
  localparam logic [5:0] CODE_KNEE   = 6'h20;
  localparam logic [5:0] UNIFORM_MAX = 6'h2F;

  // least dark sampling time and its cycle count at 250 MHz
  localparam int unsigned DARK_MIN_US      = 137;
  localparam int unsigned CLK_MHZ          = 250;
  localparam int unsigned DARK_MIN_CYC_DEF = DARK_MIN_US * CLK_MHZ;

  // bayer positions
  localparam logic [1:0] BAYER_GR   = 2'h0;
  localparam logic [1:0] BAYER_RED  = 2'h1;
  localparam logic [1:0] BAYER_BLUE = 2'h2;
  localparam logic [1:0] BAYER_GBG  = 2'h3;

  typedef enum logic [1:0] {GM_PIECEWISE, GM_UNIFORM, GM_EXTENDED}
    agc_gain_mode_e;

  typedef struct packed {
    logic [1:0]  bayer;
    logic [10:0] column;
  } agc_pix_s;

  typedef struct packed {
    logic [7:0] wb;
    logic [7:0] exp_a;
    logic [7:0] exp_b;
  } agc_gain_s;

endpackage : agc_pkg

// ### src/agc_gain_decode.sv
// gain code to fine-step count decoder for one gain path
`timescale 1ns/1ps
`default_nettype none
module agc_gain_decode
  import agc_pkg::*;
(
  // code and mode
  input  wire logic [5:0]     code,
  input  wire agc_gain_mode_e mode,
  // gain in fine steps
  output logic [7:0]          steps
);

  // coarse step is two fine steps
  always_comb begin
    steps = 8'h00;
    unique case (mode)
      GM_PIECEWISE: begin
        if (code <= CODE_KNEE) begin
          steps = {2'b00, code};
        end else begin
          steps = {1'b0, code, 1'b0} - {2'b00, CODE_KNEE};
        end
      end
      // codes above the top valid code saturate
      GM_UNIFORM: begin
        if (code > UNIFORM_MAX) begin
          steps = {1'b0, UNIFORM_MAX, 1'b0};
        end else begin
          steps = {1'b0, code, 1'b0};
        end
      end
      // a 6-bit code never exceeds the extended range
      GM_EXTENDED: steps = {1'b0, code, 1'b0};
      default:     steps = {2'b00, code};
    endcase
  end

endmodule : agc_gain_decode
`default_nettype wire

// ### src/agc_col_table.sv
// 64-entry per-column offset table, flip-flop storage, two read ports
`timescale 1ns/1ps
`default_nettype none
module agc_col_table
  import agc_pkg::*;
(
  // clock and reset
  input  wire logic       mclk,
  input  wire logic       nrst,
  // write port
  input  wire logic       wr_en,
  input  wire logic [5:0] wr_idx,
  input  wire logic [5:0] wr_data,
  // pixel and register read ports
  input  wire logic [5:0] pix_idx,
  output logic [5:0]      pix_data,
  input  wire logic [5:0] rd_idx,
  output logic [5:0]      rd_data
);

  logic [5:0] ent_q [COL_ENTRIES];

  // one entry per generate pass, cleared at reset
  for (genvar i = 0; i < COL_ENTRIES; i++) begin : g_ent
    always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
        ent_q[i] <= 6'h00;
      end else if (wr_en && (wr_idx == 6'(i))) begin
        ent_q[i] <= wr_data;
      end
    end
  end

  // reads are plain muxes
  assign pix_data = ent_q[pix_idx];
  assign rd_data  = ent_q[rd_idx];

endmodule : agc_col_table
`default_nettype wire

// ### src/agc_asp_ctrl.sv
// signal chain control: dark clamp sequencing, offsets, gains, serial port
// Functional notes
// R1: with auto clamp on, re-measure black reference at each new frame
// R2: skip the first 3 dark rows, then sample the next 2
// R3: while clamping, hold each dark pixel and force outputs to common mode
// R4: host must arrange at least 137 us of dark sampling in total
// R5: clamp can be switched off; same setting sets clamped row count
// R6: 64 column offset entries, 6 bits each, sign plus five magnitude
// R7: column offset is common DC term plus selected table entry
// R8: column index modulo 64 selects the entry, repeating per bank
// R9: common DC offset resets to zero
// R10: separate white-balance code for each of four bayer positions
// R11: codes at 00h/01h/02h/03h serve green-red, red, blue, green-blue
// R12: each white-balance code is 6-bit unsigned
// R13: gain rewrites reach the pixel path without waiting for a frame
// R14: two white-balance modes and three exposure modes are selectable
// R15: piecewise mode: 0-32 fine steps, 33-63 coarse double steps
// R16: uniform mode: only codes 0-47, equal coarse steps
// R17: extended uniform mode, exposure only, codes 0-63, coarse steps
// R18: exposure gain from two global registers at 10h and 21h
// R19: exposure codes are 6 bits, step follows exposure mode
// R20: global offset takes a 6-bit sign-magnitude code of its own
// R21: out-of-range codes saturate to the mode's largest valid code
// R22: gain and offset writes take effect at the next pixel boundary
`timescale 1ns/1ps
`default_nettype none
module agc_asp_ctrl
  import agc_pkg::*;
#(
  parameter int unsigned DARK_MIN_CYC = DARK_MIN_CYC_DEF
) (
  // clock and reset
  input  wire logic         mclk,
  input  wire logic         nrst,
  // two-wire serial register port
  input  wire logic         scl_i,
  input  wire logic         sda_i,
  output logic              sda_o,
  output logic              sda_oe,
  // readout sequencer timing
  input  wire logic         frame_start,
  input  wire logic         row_start,
  input  wire logic         row_is_dark,
  input  wire logic         pix_strobe,
  input  wire agc_pix_s     pix,
  // analog chain controls
  output logic              clamp_active,
  output logic              clamp_cm_force,
  output logic              dark_hold,
  output agc_gain_s         gain,
  output logic signed [6:0] col_offset,
  output logic [5:0]        glob_offset
);

  typedef enum logic [3:0] {
    SS_IDLE, SS_ADDR, SS_ACK_ADDR, SS_REG, SS_ACK_REG,
    SS_WDATA, SS_ACK_W, SS_RDATA, SS_RACK
  } agc_ser_e;

  typedef enum logic [1:0] {CL_IDLE, CL_SKIP, CL_SAMPLE} agc_clamp_e;

  // sign-magnitude to two's complement, used for both offset terms
  function automatic logic signed [6:0] sm2tc(input logic [5:0] v);
    logic signed [6:0] mag;
    mag = signed'({2'b00, v[SIGN_BIT-1:0]});
    return v[SIGN_BIT] ? -mag : mag;
  endfunction : sm2tc

  logic       scl_s1_q, scl_s2_q, scl_s3_q;
  logic       sda_s1_q, sda_s2_q, sda_s3_q;
  logic       scl_rise, scl_fall, start_det, stop_det;
  agc_ser_e   ser_q;
  logic [3:0] bit_q;
  logic [7:0] shift_q;
  logic [7:0] ptr_q;
  logic       rw_q;
  logic       sda_oe_q;
  logic       wr_pulse;
  logic       tab_wr;
  logic [7:0] rd_data;
  logic [5:0] code_q [4];
  logic [5:0] exp_a_q;
  logic [5:0] exp_b_q;
  logic [7:0] clamp_cfg_q;
  logic [7:0] gain_mode_q;
  logic [5:0] col_dc_q;
  logic [5:0] glob_q;
  logic       clamp_en;
  logic [2:0] clamp_rows;
  agc_clamp_e cl_q;
  logic [2:0] row_cnt_q;
  logic [16:0] dark_cyc_q;
  logic       dark_met_q;
  logic [5:0] tab_pix;
  logic [5:0] tab_rd;
  logic [5:0] wb_code;
  agc_gain_mode_e wb_mode;
  agc_gain_mode_e exp_mode;
  logic [7:0] wb_steps, exp_a_steps, exp_b_steps;

  // pins come from another domain: two flops, the third only for edges
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      scl_s1_q <= 1'b1;
      scl_s2_q <= 1'b1;
      scl_s3_q <= 1'b1;
      sda_s1_q <= 1'b1;
      sda_s2_q <= 1'b1;
      sda_s3_q <= 1'b1;
    end else begin
      scl_s1_q <= scl_i;
      scl_s2_q <= scl_s1_q;
      scl_s3_q <= scl_s2_q;
      sda_s1_q <= sda_i;
      sda_s2_q <= sda_s1_q;
      sda_s3_q <= sda_s2_q;
    end
  end

  // bus events; start and stop are sda moves while scl is high
  assign scl_rise  = scl_s2_q & ~scl_s3_q;
  assign scl_fall  = ~scl_s2_q & scl_s3_q;
  assign start_det = scl_s2_q & scl_s3_q & ~sda_s2_q & sda_s3_q;
  assign stop_det  = scl_s2_q & scl_s3_q & sda_s2_q & ~sda_s3_q;

  // open-drain data line: only ever pulled low
  assign sda_o  = 1'b0;
  assign sda_oe = sda_oe_q;

  // serial slave: address, register pointer, then data with increment
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      ser_q    <= SS_IDLE;
      bit_q    <= 4'h0;
      shift_q  <= 8'h00;
      ptr_q    <= 8'h00;
      rw_q     <= 1'b0;
      sda_oe_q <= 1'b0;
    end else if (start_det) begin
      ser_q    <= SS_ADDR;
      bit_q    <= 4'h0;
      sda_oe_q <= 1'b0;
    end else if (stop_det) begin
      ser_q    <= SS_IDLE;
      sda_oe_q <= 1'b0;
    end else if (scl_rise) begin
      if (ser_q inside {SS_ADDR, SS_REG, SS_WDATA}) begin
        shift_q <= {shift_q[6:0], sda_s2_q};
        bit_q   <= bit_q + 4'h1;
      end else if (ser_q == SS_RACK && sda_s2_q) begin
        ser_q <= SS_IDLE;  // master nack ends the read
      end
    end else if (scl_fall) begin
      unique case (ser_q)
        SS_IDLE: sda_oe_q <= 1'b0;
        SS_ADDR: begin
          if (bit_q == 4'h8) begin
            bit_q <= 4'h0;
            if (shift_q[7:1] == DEV_ADDR) begin
              rw_q     <= shift_q[0];
              sda_oe_q <= 1'b1;
              ser_q    <= SS_ACK_ADDR;
            end else begin
              ser_q <= SS_IDLE;
            end
          end
        end
        SS_REG: begin
          if (bit_q == 4'h8) begin
            bit_q    <= 4'h0;
            ptr_q    <= shift_q;
            sda_oe_q <= 1'b1;
            ser_q    <= SS_ACK_REG;
          end
        end
        SS_WDATA: begin
          if (bit_q == 4'h8) begin
            bit_q    <= 4'h0;
            ptr_q    <= ptr_q + 8'h01;
            sda_oe_q <= 1'b1;
            ser_q    <= SS_ACK_W;
          end
        end
        SS_ACK_ADDR: begin
          if (rw_q) begin
            shift_q  <= rd_data;
            sda_oe_q <= ~rd_data[7];
            ser_q    <= SS_RDATA;
          end else begin
            sda_oe_q <= 1'b0;
            ser_q    <= SS_REG;
          end
        end
        SS_ACK_REG, SS_ACK_W: begin
          sda_oe_q <= 1'b0;
          ser_q    <= SS_WDATA;
        end
        SS_RDATA: begin
          if (bit_q == 4'h7) begin
            bit_q    <= 4'h0;
            sda_oe_q <= 1'b0;
            ptr_q    <= ptr_q + 8'h01;
            ser_q    <= SS_RACK;
          end else begin
            bit_q    <= bit_q + 4'h1;
            shift_q  <= {shift_q[6:0], 1'b0};
            sda_oe_q <= ~shift_q[6];
          end
        end
        SS_RACK: begin
          shift_q  <= rd_data;
          sda_oe_q <= ~rd_data[7];
          ser_q    <= SS_RDATA;
        end
      endcase
    end
  end

  // a data byte is complete on the falling edge after its eighth bit
  assign wr_pulse = (ser_q == SS_WDATA) && scl_fall && (bit_q == 4'h8)
                    && !start_det && !stop_det;
  assign tab_wr   = wr_pulse && (ptr_q[7:6] == REG_TAB_PAGE);

  // R10 four colour codes; R18 two exposure registers; R9 dc resets 0
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < 4; i++) begin
        code_q[i] <= CODE_RST;
      end
      exp_a_q     <= CODE_RST;
      exp_b_q     <= CODE_RST;
      clamp_cfg_q <= CLAMP_CFG_RST;
      gain_mode_q <= GAIN_MODE_RST;
      col_dc_q    <= COL_DC_RST;
      glob_q      <= CODE_RST;
    end else if (wr_pulse) begin
      // R12 R19 codes keep six bits; unmapped writes are ignored
      case (ptr_q)
        REG_GAIN_GR:   code_q[0]   <= shift_q[5:0];
        REG_GAIN_RED:  code_q[1]   <= shift_q[5:0];
        REG_GAIN_BLUE: code_q[2]   <= shift_q[5:0];
        REG_GAIN_GBG:  code_q[3]   <= shift_q[5:0];
        REG_EXP_A:     exp_a_q     <= shift_q[5:0];
        REG_EXP_B:     exp_b_q     <= shift_q[5:0];
        REG_CLAMP_CFG: clamp_cfg_q <= {4'h0, shift_q[3:0]};
        REG_GAIN_MODE: gain_mode_q <= {5'h00, shift_q[2:0]};
        REG_COL_DC:    col_dc_q    <= shift_q[5:0];
        REG_GLOB_OFS:  glob_q      <= shift_q[5:0];
        default:       ;
      endcase
    end
  end

  // read mux; unmapped addresses read as zero
  always_comb begin
    rd_data = 8'h00;
    if (ptr_q[7:6] == REG_TAB_PAGE) begin
      rd_data = {2'b00, tab_rd};
    end else begin
      case (ptr_q)
        REG_GAIN_GR:   rd_data = {2'b00, code_q[0]};
        REG_GAIN_RED:  rd_data = {2'b00, code_q[1]};
        REG_GAIN_BLUE: rd_data = {2'b00, code_q[2]};
        REG_GAIN_GBG:  rd_data = {2'b00, code_q[3]};
        REG_EXP_A:     rd_data = {2'b00, exp_a_q};
        REG_EXP_B:     rd_data = {2'b00, exp_b_q};
        REG_CLAMP_CFG: rd_data = clamp_cfg_q;
        REG_GAIN_MODE: rd_data = gain_mode_q;
        REG_COL_DC:    rd_data = {2'b00, col_dc_q};
        REG_GLOB_OFS:  rd_data = {2'b00, glob_q};
        REG_STATUS:    rd_data = {5'h00, dark_met_q, cl_q == CL_SKIP,
                                  clamp_active};
        default:       rd_data = 8'h00;
      endcase
    end
  end

  // R5 enable bit and clamped row count share one register
  assign clamp_en   = clamp_cfg_q[CLAMP_EN_BIT];
  assign clamp_rows = clamp_cfg_q[CLAMP_ROWS_LSB +: 3];

  // dark clamp sequencer, rearmed at every frame start
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      cl_q      <= CL_IDLE;
      row_cnt_q <= 3'h0;
    end else if (!clamp_en) begin
      // R5 clamp off leaves the offset free
      cl_q <= CL_IDLE;
    end else if (frame_start) begin
      // R1 new frame re-measures black
      cl_q      <= CL_SKIP;
      row_cnt_q <= 3'h0;
    end else if (row_start) begin
      unique case (cl_q)
        CL_IDLE: cl_q <= CL_IDLE;
        // R2 skip three dark rows
        CL_SKIP: begin
          if (!row_is_dark) begin
            cl_q <= CL_IDLE;
          end else if (row_cnt_q == CLAMP_SKIP_ROWS) begin
            cl_q      <= (clamp_rows == 3'h0) ? CL_IDLE : CL_SAMPLE;
            row_cnt_q <= 3'h1;
          end else begin
            row_cnt_q <= row_cnt_q + 3'h1;
          end
        end
        // R5 sample the configured row count
        CL_SAMPLE: begin
          if (!row_is_dark || row_cnt_q >= clamp_rows) begin
            cl_q <= CL_IDLE;
          end else begin
            row_cnt_q <= row_cnt_q + 3'h1;
          end
        end
      endcase
    end
  end

  // R3 hold dark pixels, force common mode
  assign clamp_active   = (cl_q == CL_SAMPLE);
  assign clamp_cm_force = clamp_active;
  assign dark_hold      = clamp_active & pix_strobe & row_is_dark;

  // clamp time since enable, counted up to the minimum; status bit 2 flags when it is reached
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      dark_cyc_q <= 17'h0_0000;
      dark_met_q <= 1'b0;
    end else if (!clamp_en) begin
      dark_cyc_q <= 17'h0_0000;
      dark_met_q <= 1'b0;
    end else if (clamp_active && !dark_met_q) begin
      dark_cyc_q <= dark_cyc_q + 17'h0_0001;
      dark_met_q <= (dark_cyc_q + 17'h0_0001) >= 17'(DARK_MIN_CYC);
    end
  end

  // R6 R8 table indexed by column modulo 64
  agc_col_table u_tab (
    .mclk     (mclk),
    .nrst     (nrst),
    .wr_en    (tab_wr),
    .wr_idx   (ptr_q[5:0]),
    .wr_data  (shift_q[5:0]),
    .pix_idx  (pix.column[5:0]),
    .pix_data (tab_pix),
    .rd_idx   (ptr_q[5:0]),
    .rd_data  (tab_rd)
  );

  // R11 bayer position picks code; R14 mode fields select decoding
  always_comb begin
    unique case (pix.bayer)
      BAYER_GR:   wb_code = code_q[0];
      BAYER_RED:  wb_code = code_q[1];
      BAYER_BLUE: wb_code = code_q[2];
      BAYER_GBG:  wb_code = code_q[3];
    endcase
    wb_mode  = gain_mode_q[WB_MODE_BIT] ? GM_UNIFORM : GM_PIECEWISE;
    // unused mode code falls back to piecewise
    unique case (gain_mode_q[EXP_MODE_LSB +: 2])
      2'h1:    exp_mode = GM_UNIFORM;
      2'h2:    exp_mode = GM_EXTENDED;
      default: exp_mode = GM_PIECEWISE;
    endcase
  end

  // R15 R16 R17 R21 decoders, one per path
  agc_gain_decode u_dec_wb (.code(wb_code), .mode(wb_mode),
                            .steps(wb_steps));
  agc_gain_decode u_dec_ea (.code(exp_a_q), .mode(exp_mode),
                            .steps(exp_a_steps));
  agc_gain_decode u_dec_eb (.code(exp_b_q), .mode(exp_mode),
                            .steps(exp_b_steps));

  // R22 R13 outputs move only at a pixel boundary, no frame wait
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      gain        <= '0;
      col_offset  <= 7'sh00;
      glob_offset <= 6'h00;
    end else if (pix_strobe) begin
      gain.wb     <= wb_steps;
      gain.exp_a  <= exp_a_steps;
      gain.exp_b  <= exp_b_steps;
      // R7 dc term plus table entry
      col_offset  <= sm2tc(col_dc_q) + sm2tc(tab_pix);
      // R20 global offset code
      glob_offset <= glob_q;
    end
  end

  // checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);

  logic [2:0] dk_rows_q;
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      dk_rows_q <= 3'h0;
    end else if (frame_start) begin
      dk_rows_q <= 3'h0;
    end else if (row_start && row_is_dark && dk_rows_q != 3'h7) begin
      dk_rows_q <= dk_rows_q + 3'h1;
    end
  end

  // R2 sampling starts at fourth dark row
  skip_three_a: assert property ($rose(clamp_active) |-> // R2
    $past(dk_rows_q) == 3'h3) else $error("clamp began at wrong row");
  // R1 frame start rearms the sequencer
  frame_rearm_a: assert property (frame_start && clamp_en // R1
    && !$fell(clamp_en) |=> cl_q == CL_SKIP || !clamp_en)
    else $error("frame start did not rearm clamp");
  // R3 dark hold only under common-mode force
  dark_hold_a: assert property (dark_hold |-> clamp_cm_force // R3
    && row_is_dark) else $error("dark hold outside clamp");
  // R5 disable stops the clamp next cycle
  clamp_off_a: assert property (!clamp_en |=> !clamp_active) // R5
    else $error("clamp active while disabled");
  // R5 row count bounded by setting
  rows_bound_a: assert property (clamp_active |-> // R5
    row_cnt_q <= clamp_rows) else $error("too many rows clamped");
  // R7 column offset sum
  col_sum_a: assert property (pix_strobe |=> col_offset == // R7
    $past(sm2tc(col_dc_q) + sm2tc(tab_pix)))
    else $error("column offset sum wrong");
  // R11 red code in piecewise fine segment passes straight
  red_select_a: assert property (pix_strobe && // R11
    pix.bayer == BAYER_RED && !gain_mode_q[WB_MODE_BIT]
    && code_q[1] <= CODE_KNEE |=> gain.wb == {2'b00, $past(code_q[1])})
    else $error("red gain select wrong");
  // R16 uniform exposure saturates
  uniform_sat_a: assert property (pix_strobe && // R21
    exp_mode == GM_UNIFORM && exp_a_q > UNIFORM_MAX
    |=> gain.exp_a == 8'h5E) else $error("uniform code not saturated");
  // R22 outputs hold between pixel strobes
  pixel_hold_a: assert property (!pix_strobe |=> // R22
    $stable(gain) && $stable(col_offset)) else $error("mid-pixel change");

  clamp_seen_c: cover property ($rose(clamp_active));
  reg_write_c:  cover property (wr_pulse && ptr_q == REG_EXP_B);
  ext_mode_c:   cover property (pix_strobe && exp_mode == GM_EXTENDED);
  dark_met_c:   cover property ($rose(dark_met_q));

endmodule : agc_asp_ctrl
`default_nettype wire

// ### dv/agc_host_model.sv
// host side model: two-wire bus master for register access
`timescale 1ns/1ps
`default_nettype none
module agc_host_model
  import agc_pkg::*;
(
  // clock and resolved data line
  input  wire logic mclk,
  input  wire logic sda_w,
  // bus pins, dn high pulls the data line low
  output logic      scl,
  output logic      dn
);
  // idle bus: clock high, data released to the pull-up
  initial begin
    scl = 1'b1;
    dn  = 1'b0;
  end
  // six cycles per quarter bit leaves margin over the four-cycle minimum
  task automatic hp();
    repeat (6) @(negedge mclk);
  endtask : hp
  // one bit; data changes only while the clock is low
  task automatic bit_io(input logic b, output logic r);
    dn = !b;
    hp();
    scl = 1'b1;
    hp();
    r = sda_w;
    hp();
    scl = 1'b0;
    hp();
  endtask : bit_io
  // start, also used as repeated start
  task automatic start();
    dn = 1'b0;
    hp();
    scl = 1'b1;
    hp();
    dn = 1'b1;
    hp();
    scl = 1'b0;
    hp();
  endtask : start
  // stop leaves the bus idle
  task automatic stop();
    dn = 1'b1;
    hp();
    scl = 1'b1;
    hp();
    dn = 1'b0;
    hp();
  endtask : stop
  // byte msb first, then ninth bit; ack when the line was pulled low
  task automatic xbyte(input logic [7:0] d, input logic last,
                       output logic [7:0] q, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
    bit_io(last, r);
    ack = !r;
  endtask : xbyte
  // pointer then one data byte
  task automatic wr(input logic [7:0] a, input logic [7:0] d,
                    output logic ok);
    logic [7:0] q;
    logic       a0, a1, a2;
    start();
    xbyte({DEV_ADDR, 1'b0}, 1'b1, q, a0);
    xbyte(a, 1'b1, q, a1);
    xbyte(d, 1'b1, q, a2);
    stop();
    ok = a0 & a1 & a2;
  endtask : wr
  // pointer, repeated start, one byte read and ended by a nack
  task automatic rd(input logic [7:0] a, output logic [7:0] d,
                    output logic ok);
    logic [7:0] q;
    logic       a0, a1, a2, nk;
    start();
    xbyte({DEV_ADDR, 1'b0}, 1'b1, q, a0);
    xbyte(a, 1'b1, q, a1);
    start();
    xbyte({DEV_ADDR, 1'b1}, 1'b1, q, a2);
    xbyte(8'hFF, 1'b1, d, nk);
    stop();
    ok = a0 & a1 & a2;
  endtask : rd
endmodule : agc_host_model
`default_nettype wire

// ### dv/agc_asp_ctrl_test.sv
// self-checking bench for the signal chain control block
`timescale 1ns/1ps
`default_nettype none
module agc_asp_ctrl_test;
  import agc_pkg::*;
  logic              mclk, nrst, fs, rs, dark, ps, ok;
  logic              scl, dn, sda_w, sda_o, sda_oe, ca, cm, dh, e;
  agc_pix_s          pix;
  agc_gain_s         gain;
  logic signed [6:0] col;
  logic [5:0]        gofs;
  logic [7:0]        d;
  logic [7:0]        wbc [4] = '{8'hE0, 8'h1C, 8'h3F, 8'h05};
  int                n_fail = 0, samples_checked = 0, cyc = 0;
  // open-drain data line with pull-up
  assign sda_w = !(dn | (sda_oe & !sda_o));
  agc_host_model h (.mclk(mclk), .sda_w(sda_w), .scl(scl), .dn(dn));
  agc_asp_ctrl #(.DARK_MIN_CYC(20)) uut (.mclk(mclk), .nrst(nrst),
    .scl_i(scl), .sda_i(sda_w), .sda_o(sda_o), .sda_oe(sda_oe),
    .frame_start(fs), .row_start(rs), .row_is_dark(dark),
    .pix_strobe(ps), .pix(pix), .clamp_active(ca), .clamp_cm_force(cm),
    .dark_hold(dh), .gain(gain), .col_offset(col), .glob_offset(gofs));
  task automatic end_sim();
    if (n_fail == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : end_sim
  task automatic chk(input logic [7:0] g, input logic [7:0] x);
    samples_checked++;
    if (g !== x) begin
      n_fail++;
      $display("ERROR %0t got %h want %h", $time, g, x);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    h.wr(a, v, ok);
    chk(ok, 8'h01);
  endtask : wr
  task automatic rr(input logic [7:0] a, input logic [7:0] x);
    h.rd(a, d, ok);
    chk(ok, 8'h01);
    chk(d, x);
  endtask : rr
  // one pixel boundary; outputs are checked after the taking edge
  task automatic px(input logic [1:0] b, input logic [10:0] c);
    @(negedge mclk) ps = 1'b1;
    pix = {b, c};
    @(negedge mclk) ps = 1'b0;
  endtask : px
  task automatic row();
    @(negedge mclk) rs = 1'b1;
    @(negedge mclk) rs = 1'b0;
    repeat (16) @(negedge mclk);
  endtask : row
  // expected gain in fine steps; the knee sits at code 32
  function automatic logic [7:0] dec(input logic [5:0] c,
                                     input logic [1:0] m);
    case (m)
      2'h1:    dec = (c > 6'h2F) ? 8'h5E : {1'b0, c, 1'b0};
      2'h2:    dec = {1'b0, c, 1'b0};
      default: dec = (c > 6'h20) ? {1'b0, c, 1'b0} - 8'h20 : {2'h0, c};
    endcase
  endfunction : dec
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  // hang guard, far above the expected run length
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 80000) begin
      n_fail++;
      end_sim();
    end
  end
  initial begin
    {nrst, fs, rs, dark, ps} = '0;
    pix = '0;
    repeat (12) @(negedge mclk);
    nrst = 1'b1;
    repeat (4) @(negedge mclk);
    rr(REG_CLAMP_CFG, 8'h05);
    rr(REG_COL_DC, 8'h00);
    rr(8'h30, 8'h00);
    // codes per position, upper bits dropped
    for (int i = 0; i < 4; i++) wr(i[7:0], wbc[i]);
    for (int i = 0; i < 4; i++) rr(i[7:0], wbc[i] & 8'h3F);
    chk(gain.wb, 8'h00);
    // selection and decode, both white modes
    for (int m = 0; m < 2; m++) begin
      wr(REG_GAIN_MODE, m[7:0]);
      for (int i = 0; i < 4; i++) begin
        px(i[1:0], 11'h000);
        chk(gain.wb, dec(wbc[i][5:0], m[1:0]));
      end
    end
    // exposure registers in all three modes
    wr(REG_EXP_A, 8'h3F);
    wr(REG_EXP_B, 8'h28);
    rr(REG_EXP_B, 8'h28);
    // mode code 3 falls back to piecewise
    for (int m = 0; m < 4; m++) begin
      wr(REG_GAIN_MODE, {5'h00, m[1:0], 1'b0});
      px(BAYER_BLUE, 11'h000);
      chk(gain.exp_a, dec(6'h3F, m[1:0]));
      chk(gain.exp_b, dec(6'h28, m[1:0]));
    end
    // offsets repeat per bank of columns
    wr(REG_COL_DC, 8'h02);
    wr(8'h46, 8'h23);
    wr(8'h7F, 8'h1F);
    wr(REG_GLOB_OFS, 8'h25);
    rr(8'h46, 8'h23);
    px(BAYER_RED, 11'h046);
    chk({1'b0, col}, 8'h7F);
    px(BAYER_RED, 11'h7C6);
    chk({1'b0, col}, 8'h7F);
    px(BAYER_RED, 11'h07F);
    chk({1'b0, col}, 8'h21);
    chk({2'h0, gofs}, 8'h25);
    // clamp each frame, then switched off
    for (int f = 0; f < 3; f++) begin
      e = (f < 2);
      if (f == 2) wr(REG_CLAMP_CFG, 8'h04);
      @(negedge mclk) fs = 1'b1;
      @(negedge mclk) fs = 1'b0;
      dark = 1'b1;
      repeat (3) begin
        row();
        chk(ca, 8'h00);
      end
      row();
      chk(ca, e);
      chk(cm, e);
      @(negedge mclk) ps = 1'b1;
      #1 chk(dh, e);
      @(negedge mclk) ps = 1'b0;
      row();
      chk(ca, e);
      row();
      chk(ca, 8'h00);
      dark = 1'b0;
      // sampled rows exceed the shortened minimum
      h.rd(REG_STATUS, d, ok);
      chk({7'h00, d[2]}, e);
    end
    end_sim();
  end
endmodule : agc_asp_ctrl_test
`default_nettype wire
